//--- src/core_memory_bus_interface.sv
/*
 Routes the core's program, primary data and secondary data buses onto the
 on-chip memory ports: program flash, data RAM (wide primary port plus a narrow
 second port) and the memory-mapped peripheral window.
 Assumes memories answer reads combinationally in the cycle after the address
 is registered, and that the core samples read data two cycles after a request.
*/
// Functional notes
// - Program port takes a 21-bit word address and returns 16-bit read data.
// - Program writes use only the low 16 bits of the write bus.
// - Primary address is 24 bits, addressing byte, word and long data.
// - Peripheral registers are reached over the primary address and data buses.
// - Primary read data returns on the 32-bit read bus selected by primary address.
// - Secondary address is 24 bits and addresses whole words only.
// - Secondary read data returns on 16 bits, same cycle as primary data unless both hit the peripheral window.
// - Byte accesses force the most significant address bit to zero.
// - Data RAM primary port is 32 bits wide; other data ports are 16.
// - Flash control goes over the peripheral bus; flash data moves directly.
`timescale 1ns/100ps
module core_memory_bus_interface
   import core_memory_bus_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   // Program memory interface from the core.
   input wire logic prog_req,
   input wire logic prog_we,
   input wire logic [PROG_ADDR_W-1:0] prog_addr,
   output logic [PROG_DATA_W-1:0] prog_rdata,
   // Primary data interface from the core.
   input wire logic pri_req,
   input wire logic pri_we,
   input wire logic [1:0] pri_size,
   input wire logic [DATA_ADDR_W-1:0] primary_data_address,
   input wire logic [CORE_DATA_W-1:0] core_wdata,
   output logic [CORE_DATA_W-1:0] core_rdata,
   // Secondary data interface from the core.
   input wire logic sec_req,
   input wire logic [DATA_ADDR_W-1:0] secondary_data_address,
   output logic [SEC_DATA_W-1:0] secondary_read_data,
   output logic core_stall,
   // Flash array data port.
   output logic flash_en,
   output logic flash_we,
   output logic [PROG_ADDR_W-1:0] flash_addr,
   output logic [PROG_DATA_W-1:0] flash_wdata,
   input wire logic [PROG_DATA_W-1:0] flash_rdata,
   // Data RAM wide primary port.
   output logic ram_a_en,
   output logic ram_a_we,
   output logic [1:0] ram_a_size,
   output logic [DATA_ADDR_W-1:0] ram_a_addr,
   output logic [RAM_WIDE_W-1:0] ram_a_wdata,
   input wire logic [RAM_WIDE_W-1:0] ram_a_rdata,
   // Data RAM narrow second port, read only.
   output logic ram_b_en,
   output logic [DATA_ADDR_W-1:0] ram_b_addr,
   input wire logic [PORT_NARROW_W-1:0] ram_b_rdata,
   // Peripheral bus, which also carries flash_interface_unit control registers.
   output logic io_en,
   output logic io_we,
   output logic [DATA_ADDR_W-1:0] io_addr,
   output logic [PORT_NARROW_W-1:0] io_wdata,
   input wire logic [PORT_NARROW_W-1:0] io_rdata
);

   // Decodes a data address into the port that owns it.
   function automatic target_t decode_data(input logic [DATA_ADDR_W-1:0] addr);
      if (addr >= RAM_BASE && addr < RAM_LIMIT) begin
         decode_data = TGT_RAM;
      end else if (addr >= IO_BASE && addr < IO_LIMIT) begin
         decode_data = TGT_IO;
      end else begin
         decode_data = TGT_NONE;
      end
   endfunction : decode_data

   // Byte accesses may only reach the lower half of the space.
   function automatic logic [DATA_ADDR_W-1:0] limit_addr(input logic [DATA_ADDR_W-1:0] addr,
                                                         input logic [1:0] size);
      limit_addr = addr;
      if (size == SIZE_BYTE) begin
         limit_addr[DATA_ADDR_W-1] = 1'b0;
      end
   endfunction : limit_addr

   logic [DATA_ADDR_W-1:0] pri_addr_eff;
   target_t pri_tgt;
   target_t sec_tgt;
   logic sec_conflict;

   // Effective primary address and port selection for both data buses.
   always_comb begin
      pri_addr_eff = limit_addr(primary_data_address, pri_size);
      pri_tgt = pri_req ? decode_data(pri_addr_eff) : TGT_NONE;
      sec_tgt = sec_req ? decode_data(secondary_data_address) : TGT_NONE;
      // The wide RAM port and the narrow RAM port are independent, so only a
      // peripheral collision forces the secondary read to wait a cycle.
      sec_conflict = (sec_tgt == TGT_IO) && (pri_tgt == TGT_IO);
   end

   // Memory port strobes, all registered so every output comes from a flop.
   logic flash_en_reg, flash_en_next;
   logic flash_we_reg, flash_we_next;
   logic [PROG_ADDR_W-1:0] flash_addr_reg, flash_addr_next;
   logic [PROG_DATA_W-1:0] flash_wdata_reg, flash_wdata_next;
   logic ram_a_en_reg, ram_a_en_next;
   logic ram_a_we_reg, ram_a_we_next;
   logic [1:0] ram_a_size_reg, ram_a_size_next;
   logic [DATA_ADDR_W-1:0] ram_a_addr_reg, ram_a_addr_next;
   logic [RAM_WIDE_W-1:0] ram_a_wdata_reg, ram_a_wdata_next;
   logic ram_b_en_reg, ram_b_en_next;
   logic [DATA_ADDR_W-1:0] ram_b_addr_reg, ram_b_addr_next;
   logic io_en_reg, io_en_next;
   logic io_we_reg, io_we_next;
   logic [DATA_ADDR_W-1:0] io_addr_reg, io_addr_next;
   logic [PORT_NARROW_W-1:0] io_wdata_reg, io_wdata_next;
   logic sec_pend_reg, sec_pend_next;
   logic [DATA_ADDR_W-1:0] sec_hold_reg, sec_hold_next;
   logic core_stall_reg, core_stall_next;

   // Request phase: steer each bus onto its memory port.
   always_comb begin
      flash_en_next = prog_req && (prog_addr < FLASH_LIMIT);
      flash_we_next = prog_req && prog_we && (prog_addr < FLASH_LIMIT);
      flash_addr_next = prog_addr;
      flash_wdata_next = core_wdata[PROG_DATA_W-1:0];
      ram_a_en_next = (pri_tgt == TGT_RAM);
      ram_a_we_next = (pri_tgt == TGT_RAM) && pri_we;
      ram_a_size_next = pri_size;
      ram_a_addr_next = pri_addr_eff;
      ram_a_wdata_next = core_wdata;
      ram_b_en_next = 1'b0;
      ram_b_addr_next = secondary_data_address;
      io_en_next = (pri_tgt == TGT_IO);
      io_we_next = (pri_tgt == TGT_IO) && pri_we;
      io_addr_next = pri_addr_eff;
      io_wdata_next = core_wdata[PORT_NARROW_W-1:0];
      sec_pend_next = 1'b0;
      sec_hold_next = sec_hold_reg;
      if (sec_pend_reg) begin
         // Deferred secondary peripheral read replays now the port is free.
         io_en_next = 1'b1;
         io_we_next = 1'b0;
         io_addr_next = sec_hold_reg;
      end else if (sec_tgt == TGT_RAM) begin
         ram_b_en_next = 1'b1;
      end else if (sec_conflict) begin
         sec_pend_next = 1'b1;
         sec_hold_next = secondary_data_address;
      end else if (sec_tgt == TGT_IO) begin
         io_en_next = 1'b1;
         io_we_next = 1'b0;
         io_addr_next = secondary_data_address;
      end
      core_stall_next = sec_conflict && !sec_pend_reg;
   end

   // Registers for the request phase.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         flash_en_reg <= 1'b0;
         flash_we_reg <= 1'b0;
         flash_addr_reg <= '0;
         flash_wdata_reg <= '0;
         ram_a_en_reg <= 1'b0;
         ram_a_we_reg <= 1'b0;
         ram_a_size_reg <= SIZE_WORD;
         ram_a_addr_reg <= '0;
         ram_a_wdata_reg <= '0;
         ram_b_en_reg <= 1'b0;
         ram_b_addr_reg <= '0;
         io_en_reg <= 1'b0;
         io_we_reg <= 1'b0;
         io_addr_reg <= '0;
         io_wdata_reg <= '0;
         sec_pend_reg <= 1'b0;
         sec_hold_reg <= '0;
         core_stall_reg <= 1'b0;
      end else begin
         flash_en_reg <= flash_en_next;
         flash_we_reg <= flash_we_next;
         flash_addr_reg <= flash_addr_next;
         flash_wdata_reg <= flash_wdata_next;
         ram_a_en_reg <= ram_a_en_next;
         ram_a_we_reg <= ram_a_we_next;
         ram_a_size_reg <= ram_a_size_next;
         ram_a_addr_reg <= ram_a_addr_next;
         ram_a_wdata_reg <= ram_a_wdata_next;
         ram_b_en_reg <= ram_b_en_next;
         ram_b_addr_reg <= ram_b_addr_next;
         io_en_reg <= io_en_next;
         io_we_reg <= io_we_next;
         io_addr_reg <= io_addr_next;
         io_wdata_reg <= io_wdata_next;
         sec_pend_reg <= sec_pend_next;
         sec_hold_reg <= sec_hold_next;
         core_stall_reg <= core_stall_next;
      end
   end

   // Remembers who owns each returning word so the answer is steered back.
   target_t pri_tgt_reg, pri_tgt_next;
   target_t sec_tgt_reg, sec_tgt_next;
   logic prog_rd_reg, prog_rd_next;
   logic [PROG_DATA_W-1:0] prog_rdata_reg, prog_rdata_next;
   logic [CORE_DATA_W-1:0] core_rdata_reg, core_rdata_next;
   logic [SEC_DATA_W-1:0] sec_rdata_reg, sec_rdata_next;

   // Owner tracking for the response phase.
   always_comb begin
      prog_rd_next = flash_en_next && !flash_we_next;
      pri_tgt_next = pri_we ? TGT_NONE : pri_tgt;
      if (sec_pend_reg) begin
         sec_tgt_next = TGT_IO;
      end else if (sec_conflict) begin
         sec_tgt_next = TGT_NONE;
      end else begin
         sec_tgt_next = sec_tgt;
      end
   end

   // Response phase: both data answers are published in the same cycle, unless a peripheral collision defers the secondary.
   always_comb begin
      prog_rdata_next = prog_rdata_reg;
      if (prog_rd_reg) begin
         prog_rdata_next = flash_rdata;
      end
      core_rdata_next = READ_IDLE;
      if (pri_tgt_reg == TGT_RAM) begin
         core_rdata_next = ram_a_rdata;
      end else if (pri_tgt_reg == TGT_IO) begin
         core_rdata_next = {{(CORE_DATA_W-PORT_NARROW_W){1'b0}}, io_rdata};
      end
      sec_rdata_next = '0;
      if (sec_tgt_reg == TGT_RAM) begin
         sec_rdata_next = ram_b_rdata;
      end else if (sec_tgt_reg == TGT_IO) begin
         sec_rdata_next = io_rdata;
      end
   end

   // Registers for the response phase.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pri_tgt_reg <= TGT_NONE;
         sec_tgt_reg <= TGT_NONE;
         prog_rd_reg <= 1'b0;
         prog_rdata_reg <= '0;
         core_rdata_reg <= READ_IDLE;
         sec_rdata_reg <= '0;
      end else begin
         pri_tgt_reg <= pri_tgt_next;
         sec_tgt_reg <= sec_tgt_next;
         prog_rd_reg <= prog_rd_next;
         prog_rdata_reg <= prog_rdata_next;
         core_rdata_reg <= core_rdata_next;
         sec_rdata_reg <= sec_rdata_next;
      end
   end

   assign flash_en = flash_en_reg;
   assign flash_we = flash_we_reg;
   assign flash_addr = flash_addr_reg;
   assign flash_wdata = flash_wdata_reg;
   assign ram_a_en = ram_a_en_reg;
   assign ram_a_we = ram_a_we_reg;
   assign ram_a_size = ram_a_size_reg;
   assign ram_a_addr = ram_a_addr_reg;
   assign ram_a_wdata = ram_a_wdata_reg;
   assign ram_b_en = ram_b_en_reg;
   assign ram_b_addr = ram_b_addr_reg;
   assign io_en = io_en_reg;
   assign io_we = io_we_reg;
   assign io_addr = io_addr_reg;
   assign io_wdata = io_wdata_reg;
   assign core_stall = core_stall_reg;
   assign prog_rdata = prog_rdata_reg;
   assign core_rdata = core_rdata_reg;
   assign secondary_read_data = sec_rdata_reg;

   // Named steps of a dual read: request, then both port strobes, then data.
   sequence s_dual_ram_req;
      pri_req && !pri_we && sec_req && (pri_tgt == TGT_RAM) && (sec_tgt == TGT_RAM) && !sec_pend_reg;
   endsequence
   sequence s_both_ports;
      ram_a_en && ram_b_en;
   endsequence

   a_prog_addr_pass: assert property (@(posedge ref_clk) disable iff (rst)
      (prog_req && prog_addr < FLASH_LIMIT) |=> (flash_en && flash_addr == $past(prog_addr)))
      else $error("Program address not passed to flash.");
   a_prog_low_half: assert property (@(posedge ref_clk) disable iff (rst)
      flash_we |-> (flash_wdata == $past(core_wdata[15:0])))
      else $error("Program write data not from low half.");
   a_byte_msb_zero: assert property (@(posedge ref_clk) disable iff (rst)
      (ram_a_en && ram_a_size == SIZE_BYTE) |-> !ram_a_addr[23])
      else $error("Byte access with address MSB set.");
   a_pri_addr_pass: assert property (@(posedge ref_clk) disable iff (rst)
      (pri_req && pri_size != SIZE_BYTE && pri_tgt == TGT_RAM) |=> (ram_a_addr == $past(primary_data_address)))
      else $error("Primary address altered for non-byte access.");
   a_io_on_primary: assert property (@(posedge ref_clk) disable iff (rst)
      (pri_tgt == TGT_IO && pri_we && !sec_pend_reg) |=> (io_en && io_we && io_addr == $past(pri_addr_eff)))
      else $error("Peripheral write not carried on primary bus.");
   a_ram_wide_data: assert property (@(posedge ref_clk) disable iff (rst)
      ram_a_we |-> (ram_a_wdata == $past(core_wdata)))
      else $error("Wide RAM port lost write bits.");
   a_pri_read_back: assert property (@(posedge ref_clk) disable iff (rst)
      (pri_req && !pri_we && pri_tgt == TGT_RAM) ##1 1'b1 |=> (core_rdata == $past(ram_a_rdata)))
      else $error("Primary read data not returned.");
   a_dual_no_stall: assert property (@(posedge ref_clk) disable iff (rst)
      s_dual_ram_req |=> s_both_ports ##0 !core_stall)
      else $error("Dual RAM read stalled or serialised.");
   a_sec_same_cycle: assert property (@(posedge ref_clk) disable iff (rst)
      s_dual_ram_req ##1 s_both_ports |=> (secondary_read_data == $past(ram_b_rdata)
                                           && core_rdata == $past(ram_a_rdata)))
      else $error("Secondary data not aligned with primary data.");
   a_sec_word_addr: assert property (@(posedge ref_clk) disable iff (rst)
      (sec_tgt == TGT_RAM && !sec_pend_reg) |=> (ram_b_addr == $past(secondary_data_address)))
      else $error("Secondary word address altered.");
   a_flash_direct: assert property (@(posedge ref_clk) disable iff (rst)
      prog_rd_reg |=> (prog_rdata == $past(flash_rdata)))
      else $error("Flash read not passed directly.");

endmodule : core_memory_bus_interface

//--- src/core_memory_bus_pkg.sv
/*
 Constants for the core memory bus interface: bus widths, access size codes,
 address map of the memory ports.
 Assumes a single 20 MHz clock domain shared with the core.
*/
package core_memory_bus_pkg;
   localparam int PROG_ADDR_W = 21;
   localparam int PROG_DATA_W = 16;
   localparam int DATA_ADDR_W = 24;
   localparam int CORE_DATA_W = 32;
   localparam int SEC_DATA_W = 16;
   localparam int RAM_WIDE_W = 32;
   localparam int PORT_NARROW_W = 16;
   // Access size codes on the primary bus.
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_WORD = 2'h1;
   localparam logic [1:0] SIZE_LONG = 2'h2;
   // Address map (word addresses) of the primary data space.
   localparam logic [23:0] RAM_BASE = 24'h00_0000;
   localparam logic [23:0] RAM_LIMIT = 24'h00_0800;
   localparam logic [23:0] IO_BASE = 24'h00_F000;
   localparam logic [23:0] IO_LIMIT = 24'h01_0000;
   localparam logic [20:0] FLASH_LIMIT = 21'h00_2000;
   localparam logic [31:0] READ_IDLE = 32'h0000_0000;
   // Target selector codes.
   typedef enum logic [1:0] {
      TGT_NONE = 2'b00,
      TGT_RAM = 2'b01,
      TGT_IO = 2'b10,
      TGT_FLASH = 2'b11
   } target_t;
endpackage : core_memory_bus_pkg

//--- test/memory_port_model.sv
/*
 Behavioural model of the on-chip memories behind the core memory bus interface.
 Assumes read data is wanted combinationally while a port strobe is high.
*/
`timescale 1ns/100ps
module memory_port_model (
   input wire logic ref_clk,
   input wire logic flash_en,
   input wire logic [20:0] flash_addr,
   output logic [15:0] flash_rdata,
   input wire logic ram_a_en,
   input wire logic [23:0] ram_a_addr,
   output logic [31:0] ram_a_rdata,
   input wire logic ram_b_en,
   input wire logic [23:0] ram_b_addr,
   output logic [15:0] ram_b_rdata,
   input wire logic io_en,
   input wire logic [23:0] io_addr,
   output logic [15:0] io_rdata
);
   logic [15:0] noise_reg = 16'h1357;
   // Deselected ports show a pattern that changes every cycle, so stale data never looks valid.
   always @(posedge ref_clk) begin
      noise_reg <= ~noise_reg + 16'h0001;
   end
   // Each port answers with a value derived from its own address while it is strobed.
   always_comb begin
      flash_rdata = flash_en ? (flash_addr[15:0] ^ 16'h3C3C) : noise_reg;
      ram_a_rdata = ram_a_en ? {~ram_a_addr[15:0], ram_a_addr[15:0]} : {noise_reg, ~noise_reg};
      ram_b_rdata = ram_b_en ? (ram_b_addr[15:0] ^ 16'h5A5A) : ~noise_reg;
      io_rdata = io_en ? (io_addr[15:0] ^ 16'h0F0F) : noise_reg;
   end
endmodule : memory_port_model

//--- test/test_core_memory_bus_interface.sv
/*
 Self-checking bench for the core memory bus interface, one task per scenario.
 Assumes the memory model answers while strobes are high; inputs change at falling edges.
*/
`timescale 1ns/100ps
module test_core_memory_bus_interface;
   import core_memory_bus_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic prog_req = 1'b0, prog_we = 1'b0, pri_req = 1'b0, pri_we = 1'b0, sec_req = 1'b0;
   logic [20:0] prog_addr = 21'h00_0000;
   logic [1:0] pri_size = 2'h1;
   logic [23:0] primary_data_address = 24'h00_0000, secondary_data_address = 24'h00_0000;
   logic [31:0] core_wdata = 32'h0000_0000;
   logic [15:0] prog_rdata, secondary_read_data, flash_wdata, flash_rdata, ram_b_rdata, io_wdata, io_rdata;
   logic [31:0] core_rdata, ram_a_wdata, ram_a_rdata;
   logic core_stall, flash_en, flash_we, ram_a_en, ram_a_we, ram_b_en, io_en, io_we;
   logic [20:0] flash_addr;
   logic [1:0] ram_a_size;
   logic [23:0] ram_a_addr, ram_b_addr, io_addr;
   int bad_count = 0, total_checks = 0, cycle_count = 0;

   core_memory_bus_interface dut (.ref_clk(ref_clk), .rst(rst), .prog_req(prog_req), .prog_we(prog_we),
      .prog_addr(prog_addr), .prog_rdata(prog_rdata), .pri_req(pri_req), .pri_we(pri_we), .pri_size(pri_size),
      .primary_data_address(primary_data_address), .core_wdata(core_wdata), .core_rdata(core_rdata),
      .sec_req(sec_req), .secondary_data_address(secondary_data_address),
      .secondary_read_data(secondary_read_data), .core_stall(core_stall), .flash_en(flash_en),
      .flash_we(flash_we), .flash_addr(flash_addr), .flash_wdata(flash_wdata), .flash_rdata(flash_rdata),
      .ram_a_en(ram_a_en), .ram_a_we(ram_a_we), .ram_a_size(ram_a_size), .ram_a_addr(ram_a_addr),
      .ram_a_wdata(ram_a_wdata), .ram_a_rdata(ram_a_rdata), .ram_b_en(ram_b_en), .ram_b_addr(ram_b_addr),
      .ram_b_rdata(ram_b_rdata), .io_en(io_en), .io_we(io_we), .io_addr(io_addr), .io_wdata(io_wdata),
      .io_rdata(io_rdata));
   memory_port_model mem (.ref_clk(ref_clk), .flash_en(flash_en), .flash_addr(flash_addr),
      .flash_rdata(flash_rdata), .ram_a_en(ram_a_en), .ram_a_addr(ram_a_addr), .ram_a_rdata(ram_a_rdata),
      .ram_b_en(ram_b_en), .ram_b_addr(ram_b_addr), .ram_b_rdata(ram_b_rdata), .io_en(io_en),
      .io_addr(io_addr), .io_rdata(io_rdata));

   // A 50 ns period gives the 20 MHz core clock.
   always #25 ref_clk = ~ref_clk;

   // A hung scenario is cut short well beyond the few dozen cycles the run needs.
   always @(posedge ref_clk) begin
      cycle_count++;
      if (cycle_count >= 2000) begin
         bad_count++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("Checks made: %0d, mismatches: %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   // Lets one falling edge pass first, so a request line is never written twice in one time step.
   // Then presents one request for a single cycle and waits a bounded time for a flash, wide RAM or peripheral strobe.
   task automatic issue(input logic p, input logic pw, input logic [20:0] pa, input logic d, input logic dw,
                        input logic [1:0] sz, input logic [23:0] da, input logic [31:0] wd,
                        input logic s, input logic [23:0] sa);
      @(negedge ref_clk);
      prog_req = p;
      prog_we = pw;
      prog_addr = pa;
      pri_req = d;
      pri_we = dw;
      pri_size = sz;
      primary_data_address = da;
      core_wdata = wd;
      sec_req = s;
      secondary_data_address = sa;
      @(negedge ref_clk);
      prog_req = 1'b0;
      pri_req = 1'b0;
      sec_req = 1'b0;
      prog_we = 1'b0;
      pri_we = 1'b0;
      for (int i = 0; i < 3 && !(flash_en === 1'b1 || ram_a_en === 1'b1 || io_en === 1'b1); i++) begin
         @(negedge ref_clk);
      end
   endtask : issue

   task automatic t_prog_read();
      issue(1'b1, 1'b0, 21'h00_1ABC, 1'b0, 1'b0, 2'h1, 24'h00_0000, 32'h0000_0000, 1'b0, 24'h00_0000);
      chk(32'(flash_en), 32'h0000_0001, "flash_en");
      chk(32'(flash_addr), 32'h0000_1ABC, "flash_addr");
      @(negedge ref_clk);
      chk(32'(prog_rdata), 32'h0000_2680, "prog_rdata");
      @(negedge ref_clk);
      chk(32'(prog_rdata), 32'h0000_2680, "prog_rdata held");
   endtask : t_prog_read

   task automatic t_prog_write();
      issue(1'b1, 1'b1, 21'h00_0123, 1'b0, 1'b0, 2'h1, 24'h00_0000, 32'hDEAD_BEEF, 1'b0, 24'h00_0000);
      chk(32'(flash_we), 32'h0000_0001, "flash_we");
      chk(32'(flash_wdata), 32'h0000_BEEF, "flash_wdata");
   endtask : t_prog_write

   task automatic t_dual_read();
      issue(1'b0, 1'b0, 21'h00_0000, 1'b1, 1'b0, SIZE_WORD, 24'h00_0100, 32'h0000_0000, 1'b1, 24'h00_07FF);
      chk(32'(ram_b_en), 32'h0000_0001, "ram_b_en");
      chk(32'(ram_b_addr), 32'h0000_07FF, "ram_b_addr");
      chk(32'(ram_a_addr), 32'h0000_0100, "ram_a_addr");
      chk(32'(core_stall), 32'h0000_0000, "core_stall");
      @(negedge ref_clk);
      chk(core_rdata, 32'hFEFF_0100, "core_rdata");
      chk(32'(secondary_read_data), 32'h0000_5DA5, "secondary_read_data");
   endtask : t_dual_read

   // Primary and secondary peripheral reads collide: the core stalls one cycle, then the secondary is replayed with the stall released.
   task automatic t_io_conflict();
      issue(1'b0, 1'b0, 21'h00_0000, 1'b1, 1'b0, SIZE_WORD, 24'h00_F030, 32'h0000_0000, 1'b1, 24'h00_F040);
      chk(32'(core_stall), 32'h0000_0001, "core_stall");
      chk(32'(io_addr), 32'h0000_F030, "io_addr primary");
      @(negedge ref_clk);
      chk(core_rdata, 32'h0000_FF3F, "io primary data");
      chk(32'({io_en, core_stall}), 32'h0000_0002, "replay strobe");
      chk(32'(io_addr), 32'h0000_F040, "io_addr replay");
      @(negedge ref_clk);
      chk(32'(secondary_read_data), 32'h0000_FF4F, "secondary io data");
   endtask : t_io_conflict

   task automatic t_long_write();
      issue(1'b0, 1'b0, 21'h00_0000, 1'b1, 1'b1, SIZE_LONG, 24'h00_0200, 32'hCAFE_F00D, 1'b0, 24'h00_0000);
      chk(32'(ram_a_we), 32'h0000_0001, "ram_a_we");
      chk(32'(ram_a_size), 32'h0000_0002, "ram_a_size");
      chk(ram_a_wdata, 32'hCAFE_F00D, "ram_a_wdata");
   endtask : t_long_write

   task automatic t_byte_msb();
      issue(1'b0, 1'b0, 21'h00_0000, 1'b1, 1'b0, SIZE_BYTE, 24'h80_0040, 32'h0000_0000, 1'b0, 24'h00_0000);
      chk(32'(ram_a_en), 32'h0000_0001, "ram_a_en");
      chk(32'(ram_a_addr), 32'h0000_0040, "ram_a_addr");
   endtask : t_byte_msb

   task automatic t_io();
      issue(1'b0, 1'b0, 21'h00_0000, 1'b1, 1'b1, SIZE_WORD, 24'h00_F010, 32'h1234_5678, 1'b0, 24'h00_0000);
      chk(32'(io_we), 32'h0000_0001, "io_we");
      chk(32'(io_addr), 32'h0000_F010, "io_addr");
      chk(32'(io_wdata), 32'h0000_5678, "io_wdata");
      issue(1'b0, 1'b0, 21'h00_0000, 1'b1, 1'b0, SIZE_WORD, 24'h00_F020, 32'h0000_0000, 1'b0, 24'h00_0000);
      chk(32'(io_en), 32'h0000_0001, "io_en");
      @(negedge ref_clk);
      chk(core_rdata, 32'h0000_FF2F, "io read data");
   endtask : t_io

   // An address outside every window must raise no strobe and return zero.
   task automatic t_refused();
      issue(1'b1, 1'b0, 21'h00_2000, 1'b1, 1'b0, SIZE_WORD, 24'h00_4000, 32'h0000_0000, 1'b0, 24'h00_0000);
      chk(32'({flash_en, ram_a_en, io_en}), 32'h0000_0000, "strobes");
      chk(core_rdata, 32'h0000_0000, "core_rdata");
   endtask : t_refused

   // Reset for two cycles, then run each scenario in turn.
   initial begin
      repeat (2) @(negedge ref_clk);
      rst = 1'b0;
      @(negedge ref_clk);
      t_prog_read();
      t_prog_write();
      t_dual_read();
      t_long_write();
      t_byte_msb();
      t_io();
      t_io_conflict();
      t_refused();
      repeat (2) @(negedge ref_clk);
      tally_and_finish();
   end
endmodule : test_core_memory_bus_interface
